//--- logic/irq_pkg.sv
// Package with the register map, flag layout and bus types of the interrupt request block
package irq_pkg;

  // Register byte addresses
  localparam logic [7:0] TMR_EXT_CTRL_OFS = 8'h88;
  localparam logic [7:0] SERIAL_FLAGS_OFS = 8'h98;
  localparam logic [7:0] IRQ_EN_LOW_OFS = 8'ha8;
  localparam logic [7:0] PRIO_LOW_OFS = 8'hac;
  localparam logic [7:0] IRQ_EN_HIGH_OFS = 8'hb8;
  localparam logic [7:0] PRIO_HIGH_OFS = 8'hbc;
  localparam logic [7:0] IRQ_REQ_OFS = 8'hc0;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'hd0;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [5:0] PRIO_RST = 6'h00;
  localparam logic [13:0] FLAG_RST = 14'h0000;

  // Sources in polling order; a pair is two neighbouring indices
  localparam int NUM_SRC = 12;
  localparam int NUM_FLAG = 14;
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_CONV = 4'h1;
  localparam logic [3:0] SRC_TMR0 = 4'h2;
  localparam logic [3:0] SRC_EXT2 = 4'h3;
  localparam logic [3:0] SRC_EXT1 = 4'h4;
  localparam logic [3:0] SRC_EXT3 = 4'h5;
  localparam logic [3:0] SRC_TMR1 = 4'h6;
  localparam logic [3:0] SRC_EXT4 = 4'h7;
  localparam logic [3:0] SRC_SERIAL = 4'h8;
  localparam logic [3:0] SRC_EXT5 = 4'h9;
  localparam logic [3:0] SRC_TMR2 = 4'ha;
  localparam logic [3:0] SRC_EXT6 = 4'hb;

  // Flag vector: bits 0..11 match the sources, serial and timer 2 have a second flag
  localparam int F_RX = 8;
  localparam int F_TMR2OVF = 10;
  localparam int F_TX = 12;
  localparam int F_TMR2RLD = 13;

  // Field positions in the timer and external control register
  localparam int TC_EXT0_SEL = 0;
  localparam int TC_EXT0_REQ = 1;
  localparam int TC_EXT1_SEL = 2;
  localparam int TC_EXT1_REQ = 3;
  localparam int TC_TMR0_RUN = 4;
  localparam int TC_TMR0_OVF = 5;
  localparam int TC_TMR1_RUN = 6;
  localparam int TC_TMR1_OVF = 7;

  // Field positions in the enable registers
  localparam int EN0_GLOBAL = 7;
  localparam int EN1_RELOAD = 7;

  // Captured address phase
  typedef struct packed {
    logic [7:0] addr;
    logic write;
  } ahb_addr_s;

  // Offer to the CPU vectoring logic
  typedef struct packed {
    logic valid;
    logic [3:0] src;
    logic [1:0] level;
  } cpu_offer_s;

endpackage

//--- logic/irq_request_enable_logic.sv
// Interrupt request flags, enables, priority offer and AHB-Lite register slave
//
// Behaviour
// - twelve sources, five internal, seven external
// - condition sets flag regardless of enables, except timer 2 reload (needs reload enable)
// - recurring condition keeps flag at one
// - flag counts only with its enable
// - global enable zero blocks every interrupt
// - enables for ext0, timer0, ext1, timer1, serial
// - one timer 2 enable, one converter enable
// - ext2..6 enables also gate compare requests
// - reload enable blocks only the reload request
// - type bit picks falling edge or low level
// - edge mode: falling edge sets ext flag
// - vectoring clears ext0/1 flag only in edge
// - level mode: flag follows pin level directly
// - timer 0/1 flags set on rollover, cleared vectoring
// - serial request is rx OR tx, no clear
// - timer 2 request is ovf OR reload, no clear
// - software writes set or clear request flags
// - two bits give each pair four levels
// - only strictly higher level may preempt
`timescale 1ns/1ps

module irq_request_enable_logic
  import irq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  input wire logic tmr0_rollover,
  input wire logic tmr1_rollover,
  input wire logic rx_done_evt,
  input wire logic tx_done_evt,
  input wire logic tmr2_ovf_evt,
  input wire logic tmr2_reload_evt,
  input wire logic conv_done_evt,
  input wire logic [4:0] ext_hi_evt,
  input wire logic irq_ack,
  input wire logic [3:0] ack_src,
  input wire logic irq_ret,
  output logic [11:0] irq_pending,
  output irq_pkg::cpu_offer_s cpu_offer,
  output logic tmr0_run,
  output logic tmr1_run
);
  import irq_pkg::*;

  ahb_addr_s addr_ff;
  logic wait_ff;
  logic hready_ff;
  logic [31:0] rdata_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] irq_enable_low_ff;
  logic [7:0] irq_enable_high_ff;
  logic [5:0] prio_lo_ff;
  logic [5:0] prio_hi_ff;
  logic [13:0] flag_ff;
  logic [13:0] nxt_flag;
  logic pin0_prev_ff;
  logic pin1_prev_ff;
  logic [11:0] pend_ff;
  logic [3:0] in_svc_ff;
  logic [3:0] nxt_in_svc;
  cpu_offer_s offer_ff;
  cpu_offer_s nxt_offer;

  // Bus decode: accept a transfer, then one wait cycle in which it is carried out
  wire accept = hsel && htrans[1] && hready;
  wire do_wr = wait_ff && addr_ff.write;
  wire wr_ctrl = do_wr && (addr_ff.addr == TMR_EXT_CTRL_OFS);
  wire wr_serial = do_wr && (addr_ff.addr == SERIAL_FLAGS_OFS);
  wire wr_irq_enable_low = do_wr && (addr_ff.addr == IRQ_EN_LOW_OFS);
  wire wr_irq_enable_high = do_wr && (addr_ff.addr == IRQ_EN_HIGH_OFS);
  wire wr_prio_lo = do_wr && (addr_ff.addr == PRIO_LOW_OFS);
  wire wr_prio_hi = do_wr && (addr_ff.addr == PRIO_HIGH_OFS);
  wire wr_req = do_wr && (addr_ff.addr == IRQ_REQ_OFS);
  wire [7:0] wbyte = hwdata[7:0];

  wire edge0 = ctrl_ff[TC_EXT0_SEL];
  wire edge1 = ctrl_ff[TC_EXT1_SEL];

  // falling edge detect on the external pins
  wire fall0 = pin0_prev_ff && !ext_irq0_pin;
  wire fall1 = pin1_prev_ff && !ext_irq1_pin;

  // Hardware set conditions per flag
  wire [13:0] hw_set;
  // five internal and seven external sources
  assign hw_set[SRC_EXT0] = edge0 && fall0;
  assign hw_set[SRC_CONV] = conv_done_evt;
  assign hw_set[SRC_TMR0] = tmr0_rollover;
  assign hw_set[SRC_EXT2] = ext_hi_evt[0];
  assign hw_set[SRC_EXT1] = edge1 && fall1;
  assign hw_set[SRC_EXT3] = ext_hi_evt[1];
  assign hw_set[SRC_TMR1] = tmr1_rollover;
  assign hw_set[SRC_EXT4] = ext_hi_evt[2];
  assign hw_set[F_RX] = rx_done_evt;
  assign hw_set[SRC_EXT5] = ext_hi_evt[3];
  assign hw_set[F_TMR2OVF] = tmr2_ovf_evt;
  assign hw_set[SRC_EXT6] = ext_hi_evt[4];
  assign hw_set[F_TX] = tx_done_evt;
  // reload request gated here, the reload itself is outside
  assign hw_set[F_TMR2RLD] = tmr2_reload_evt && irq_enable_high_ff[EN1_RELOAD];

  // Software write enables and values per flag
  wire [13:0] sw_we;
  wire [13:0] sw_val;
  // writes act like hardware, except ext0/1 in level mode
  assign sw_we[SRC_EXT0] = wr_ctrl && edge0;
  assign sw_val[SRC_EXT0] = wbyte[TC_EXT0_REQ];
  assign sw_we[SRC_EXT1] = wr_ctrl && edge1;
  assign sw_val[SRC_EXT1] = wbyte[TC_EXT1_REQ];
  assign sw_we[SRC_TMR0] = wr_ctrl;
  assign sw_val[SRC_TMR0] = wbyte[TC_TMR0_OVF];
  assign sw_we[SRC_TMR1] = wr_ctrl;
  assign sw_val[SRC_TMR1] = wbyte[TC_TMR1_OVF];
  assign sw_we[F_RX] = wr_serial;
  assign sw_val[F_RX] = wbyte[0];
  assign sw_we[F_TX] = wr_serial;
  assign sw_val[F_TX] = wbyte[1];
  assign sw_we[SRC_CONV] = wr_req;
  assign sw_val[SRC_CONV] = wbyte[0];
  assign sw_we[SRC_EXT2] = wr_req;
  assign sw_val[SRC_EXT2] = wbyte[1];
  assign sw_we[SRC_EXT3] = wr_req;
  assign sw_val[SRC_EXT3] = wbyte[2];
  assign sw_we[SRC_EXT4] = wr_req;
  assign sw_val[SRC_EXT4] = wbyte[3];
  assign sw_we[SRC_EXT5] = wr_req;
  assign sw_val[SRC_EXT5] = wbyte[4];
  assign sw_we[SRC_EXT6] = wr_req;
  assign sw_val[SRC_EXT6] = wbyte[5];
  assign sw_we[F_TMR2OVF] = wr_req;
  assign sw_val[F_TMR2OVF] = wbyte[6];
  assign sw_we[F_TMR2RLD] = wr_req;
  assign sw_val[F_TMR2RLD] = wbyte[7];

  // vectoring clear at the acceptance edge
  wire [11:0] ack_hit;
  wire [13:0] ack_clr;
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_ack
    assign ack_hit[g] = irq_ack && (ack_src == 4'(g));
  end
  // ext0/1 cleared only when edge triggered
  assign ack_clr[SRC_EXT0] = ack_hit[SRC_EXT0] && edge0;
  assign ack_clr[SRC_EXT1] = ack_hit[SRC_EXT1] && edge1;
  assign ack_clr[SRC_TMR0] = ack_hit[SRC_TMR0];
  assign ack_clr[SRC_TMR1] = ack_hit[SRC_TMR1];
  assign ack_clr[SRC_EXT2] = ack_hit[SRC_EXT2];
  assign ack_clr[SRC_EXT3] = ack_hit[SRC_EXT3];
  assign ack_clr[SRC_EXT4] = ack_hit[SRC_EXT4];
  assign ack_clr[SRC_EXT5] = ack_hit[SRC_EXT5];
  assign ack_clr[SRC_EXT6] = ack_hit[SRC_EXT6];
  assign ack_clr[F_RX] = 1'b0;
  assign ack_clr[F_TX] = 1'b0;
  // timer 2 flags kept on vectoring
  assign ack_clr[F_TMR2OVF] = 1'b0;
  assign ack_clr[F_TMR2RLD] = 1'b0;
  assign ack_clr[SRC_CONV] = 1'b0;

  // Next flag values; a hardware set beats any clear
  always_comb begin
    // a repeated set just holds the one
    nxt_flag = hw_set | (sw_we & sw_val) | (~sw_we & flag_ff & ~ack_clr);
    // level mode flag mirrors the low pin
    if (!edge0) begin
      nxt_flag[SRC_EXT0] = !ext_irq0_pin;
    end
    if (!edge1) begin
      nxt_flag[SRC_EXT1] = !ext_irq1_pin;
    end
  end

  // Combined request per source
  wire [11:0] src_req;
  assign src_req[7:0] = flag_ff[7:0];
  // serial request is rx or tx
  assign src_req[SRC_SERIAL] = flag_ff[F_RX] || flag_ff[F_TX];
  assign src_req[SRC_EXT5] = flag_ff[SRC_EXT5];
  // timer 2 request is overflow or reload
  assign src_req[SRC_TMR2] = flag_ff[F_TMR2OVF] || flag_ff[F_TMR2RLD];
  assign src_req[SRC_EXT6] = flag_ff[SRC_EXT6];

  // Individual enables in source order
  wire [11:0] src_en;
  // ext0/1, timer 0/1/2 and serial enables in the low enable register, converter and ext2..6 enables in the high one
  assign src_en[SRC_EXT0] = irq_enable_low_ff[0];
  assign src_en[SRC_TMR0] = irq_enable_low_ff[1];
  assign src_en[SRC_EXT1] = irq_enable_low_ff[2];
  assign src_en[SRC_TMR1] = irq_enable_low_ff[3];
  assign src_en[SRC_SERIAL] = irq_enable_low_ff[4];
  assign src_en[SRC_TMR2] = irq_enable_low_ff[5];
  assign src_en[SRC_CONV] = irq_enable_high_ff[0];
  // ext2..6 enables, shared with compare events
  assign src_en[SRC_EXT2] = irq_enable_high_ff[1];
  assign src_en[SRC_EXT3] = irq_enable_high_ff[2];
  assign src_en[SRC_EXT4] = irq_enable_high_ff[3];
  assign src_en[SRC_EXT5] = irq_enable_high_ff[4];
  assign src_en[SRC_EXT6] = irq_enable_high_ff[5];

  wire [11:0] pend_c = src_req & src_en & {NUM_SRC{irq_enable_low_ff[EN0_GLOBAL]}};

  // level of a source from its pair's two bits
  function automatic logic [1:0] src_level(input logic [3:0] s, input logic [5:0] lo,
                                           input logic [5:0] hi);
    logic [2:0] p;
    p = s[3:1];
    return {hi[p], lo[p]};
  endfunction

  // Highest level currently in service
  logic act_any;
  logic [1:0] act_lvl;
  always_comb begin
    act_any = |in_svc_ff;
    act_lvl = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (in_svc_ff[l]) begin
        act_lvl = 2'(l);
      end
    end
  end

  // Pick the best pending source: highest level, then polling order
  logic best_found;
  logic [3:0] best_src;
  logic [1:0] best_lvl;
  always_comb begin
    best_found = 1'b0;
    best_src = 4'h0;
    best_lvl = 2'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (pend_ff[i] && (!best_found || src_level(4'(i), prio_lo_ff, prio_hi_ff) > best_lvl)) begin
        best_found = 1'b1;
        best_src = 4'(i);
        best_lvl = src_level(4'(i), prio_lo_ff, prio_hi_ff);
      end
    end
    // offer only a strictly higher level than the one in service
    nxt_offer.valid = best_found && (!act_any || best_lvl > act_lvl);
    nxt_offer.src = best_src;
    nxt_offer.level = best_lvl;
  end

  // In-service levels: return drops the top one, acceptance adds one
  wire [1:0] ack_lvl = src_level(ack_src, prio_lo_ff, prio_hi_ff);
  always_comb begin
    nxt_in_svc = in_svc_ff;
    if (irq_ret && act_any) begin
      nxt_in_svc[act_lvl] = 1'b0;
    end
    if (irq_ack) begin
      nxt_in_svc[ack_lvl] = 1'b1;
    end
  end

  // Read data selection
  logic [31:0] rd_mux;
  always_comb begin
    unique case (addr_ff.addr)
      TMR_EXT_CTRL_OFS: rd_mux = {24'h0, flag_ff[SRC_TMR1], ctrl_ff[TC_TMR1_RUN],
                                  flag_ff[SRC_TMR0], ctrl_ff[TC_TMR0_RUN], flag_ff[SRC_EXT1],
                                  ctrl_ff[TC_EXT1_SEL], flag_ff[SRC_EXT0], ctrl_ff[TC_EXT0_SEL]};
      SERIAL_FLAGS_OFS: rd_mux = {30'h0, flag_ff[F_TX], flag_ff[F_RX]};
      IRQ_EN_LOW_OFS: rd_mux = {24'h0, irq_enable_low_ff};
      IRQ_EN_HIGH_OFS: rd_mux = {24'h0, irq_enable_high_ff};
      PRIO_LOW_OFS: rd_mux = {26'h0, prio_lo_ff};
      PRIO_HIGH_OFS: rd_mux = {26'h0, prio_hi_ff};
      IRQ_REQ_OFS: rd_mux = {24'h0, flag_ff[F_TMR2RLD], flag_ff[F_TMR2OVF], flag_ff[SRC_EXT6],
                             flag_ff[SRC_EXT5], flag_ff[SRC_EXT4], flag_ff[SRC_EXT3],
                             flag_ff[SRC_EXT2], flag_ff[SRC_CONV]};
      IRQ_STATUS_OFS: rd_mux = {16'h0, in_svc_ff, pend_ff};
      default: rd_mux = 32'h0;
    endcase
  end

  // Bus handshake: one wait cycle per transfer, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff <= '0;
      wait_ff <= 1'b0;
      hready_ff <= 1'b1;
      rdata_ff <= 32'h0;
    end else begin
      wait_ff <= accept;
      hready_ff <= !accept;
      if (accept) begin
        addr_ff <= '{addr: haddr[7:0] & {haddr[31:8] == 24'h0, 7'h7f}, write: hwrite};
      end
      if (wait_ff && !addr_ff.write) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // Software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= CTRL_RST;
      irq_enable_low_ff <= IEN_RST;
      irq_enable_high_ff <= IEN_RST;
      prio_lo_ff <= PRIO_RST;
      prio_hi_ff <= PRIO_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= wbyte;
      end
      if (wr_irq_enable_low) begin
        irq_enable_low_ff <= wbyte;
      end
      if (wr_irq_enable_high) begin
        irq_enable_high_ff <= wbyte;
      end
      if (wr_prio_lo) begin
        prio_lo_ff <= wbyte[5:0];
      end
      if (wr_prio_hi) begin
        prio_hi_ff <= wbyte[5:0];
      end
    end
  end

  // Flags, pin history, pending, service state and offer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_ff <= FLAG_RST;
      pin0_prev_ff <= 1'b1;
      pin1_prev_ff <= 1'b1;
      pend_ff <= 12'h000;
      in_svc_ff <= 4'h0;
      offer_ff <= '0;
    end else begin
      flag_ff <= nxt_flag;
      pin0_prev_ff <= ext_irq0_pin;
      pin1_prev_ff <= ext_irq1_pin;
      pend_ff <= pend_c;
      in_svc_ff <= nxt_in_svc;
      offer_ff <= nxt_offer;
    end
  end

  assign hrdata = rdata_ff;
  assign hreadyout = hready_ff;
  assign hresp = 1'b0;
  assign irq_pending = pend_ff;
  assign cpu_offer = offer_ff;
  assign tmr0_run = ctrl_ff[TC_TMR0_RUN];
  assign tmr1_run = ctrl_ff[TC_TMR1_RUN];

  // Checks
  sequence s_fall_ext0;
    edge0 && ext_irq0_pin ##1 edge0 && !ext_irq0_pin;
  endsequence

  chk_edge_sets_ext0: assert property (@(posedge hclk) disable iff (!hresetn)
    s_fall_ext0 |=> flag_ff[SRC_EXT0]) else $error("falling edge did not set ext0 flag");

  chk_level_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    !edge1 |=> flag_ff[SRC_EXT1] == !$past(ext_irq1_pin))
    else $error("level mode ext1 flag does not mirror pin");

  chk_ovf_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    tmr1_rollover ##1 1'b1 |-> flag_ff[SRC_TMR1]) else $error("timer 1 rollover lost");

  chk_tmr_ack_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_ack && ack_src == SRC_TMR0 && !tmr0_rollover && !wr_ctrl |=> !flag_ff[SRC_TMR0])
    else $error("timer 0 flag not cleared on vectoring");

  chk_serial_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_ack && ack_src == SRC_SERIAL && flag_ff[F_RX] && !wr_serial |=> flag_ff[F_RX])
    else $error("serial flag cleared by vectoring");

  chk_reload_block: assert property (@(posedge hclk) disable iff (!hresetn)
    tmr2_reload_evt && !irq_enable_high_ff[EN1_RELOAD] && !flag_ff[F_TMR2RLD] && !wr_req
    |=> !flag_ff[F_TMR2RLD]) else $error("reload flag set while reload enable is off");

  chk_global_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !irq_enable_low_ff[EN0_GLOBAL] ##1 !irq_enable_low_ff[EN0_GLOBAL]
    |-> ##1 (irq_pending == 12'h000 && !cpu_offer.valid))
    else $error("interrupt offered with global enable off");

  chk_pending_form: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> irq_pending[SRC_SERIAL] ==
      $past((flag_ff[F_RX] || flag_ff[F_TX]) && irq_enable_low_ff[4] && irq_enable_low_ff[EN0_GLOBAL]))
    else $error("pending vector wrong");

  chk_preempt_level: assert property (@(posedge hclk) disable iff (!hresetn)
    cpu_offer.valid && $past(act_any) |-> cpu_offer.level > $past(act_lvl))
    else $error("offer does not exceed in-service level");

  chk_bus_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    accept |=> !hreadyout ##1 hreadyout) else $error("bus answer timing wrong");

endmodule

//--- testbench/cpu_core_model.sv
// Behavioural model of the CPU vectoring logic that accepts offered sources
`timescale 1ns/1ps

module cpu_core_model
  import irq_pkg::*;
#(
  parameter int HOLD = 4
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input irq_pkg::cpu_offer_s cpu_offer,
  input wire logic ret_req,
  output logic irq_ack,
  output logic [3:0] ack_src,
  output logic irq_ret,
  output logic [3:0] last_src,
  output logic [7:0] ack_count
);
  import irq_pkg::*;
  logic [3:0] hold_ff;

  // one-cycle acceptance pulse
  // Accepts a valid offer, then ignores the stale offer for a few cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ack <= 1'b0;
      ack_src <= 4'h0;
      irq_ret <= 1'b0;
      last_src <= 4'h0;
      ack_count <= 8'h00;
      hold_ff <= 4'h0;
    end else begin
      irq_ret <= ret_req;
      irq_ack <= 1'b0;
      ack_src <= ~ack_src; // Not qualified outside an acceptance
      if (hold_ff != 4'h0) begin
        hold_ff <= hold_ff - 4'h1;
      end else if (cpu_offer.valid === 1'b1) begin
        irq_ack <= 1'b1;
        ack_src <= cpu_offer.src;
        last_src <= cpu_offer.src;
        ack_count <= ack_count + 8'h01;
        hold_ff <= 4'(HOLD);
      end
    end
  end
endmodule

//--- testbench/irq_request_enable_logic_tb.sv
// Self-checking testbench of the interrupt request and enable block
`timescale 1ns/1ps

module irq_request_enable_logic_tb;
  import irq_pkg::*;
  logic hclk, hresetn, hsel, hwrite, ret_req, pin0, pin1;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic hreadyout, hresp, irq_ack, irq_ret, tmr0_run, tmr1_run;
  logic [3:0] ack_src, last_src;
  logic [7:0] ack_count, cnt;
  logic [11:0] evt, irq_pending;
  cpu_offer_s cpu_offer;
  int err_count, tests_run;

  // Clock of 50 ns period
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  irq_request_enable_logic uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_irq0_pin(pin0),
    .ext_irq1_pin(pin1), .tmr0_rollover(evt[0]), .tmr1_rollover(evt[1]),
    .rx_done_evt(evt[2]), .tx_done_evt(evt[3]), .tmr2_ovf_evt(evt[4]),
    .tmr2_reload_evt(evt[5]), .conv_done_evt(evt[6]), .ext_hi_evt(evt[11:7]),
    .irq_ack(irq_ack), .ack_src(ack_src), .irq_ret(irq_ret), .irq_pending(irq_pending),
    .cpu_offer(cpu_offer), .tmr0_run(tmr0_run), .tmr1_run(tmr1_run));

  cpu_core_model cpu (.hclk(hclk), .hresetn(hresetn), .cpu_offer(cpu_offer),
    .ret_req(ret_req), .irq_ack(irq_ack), .ack_src(ack_src), .irq_ret(irq_ret),
    .last_src(last_src), .ack_count(ack_count));

  // Value comparison and final report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // AHB-Lite single word transfer
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        conclude();
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(rd, {24'h0, exp});
  endtask
  // Event pulse and return request, each one cycle long
  task automatic pulse(input int i);
    @(posedge hclk);
    evt[i] <= 1'b1;
    @(posedge hclk);
    evt[i] <= 1'b0;
    repeat (5) @(posedge hclk);
  endtask
  task automatic ret;
    @(posedge hclk);
    ret_req <= 1'b1;
    @(posedge hclk);
    ret_req <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask

  // Reset values, read-back, unmapped place and run bits
  task automatic t_regs;
    rd_chk(TMR_EXT_CTRL_OFS, 8'h00);
    rd_chk(IRQ_EN_LOW_OFS, 8'h00);
    rd_chk(IRQ_EN_HIGH_OFS, 8'h00);
    wr(8'h04, 8'hff);
    rd_chk(8'h04, 8'h00);
    wr(IRQ_EN_HIGH_OFS, 8'h3f);
    rd_chk(IRQ_EN_HIGH_OFS, 8'h3f);
    wr(IRQ_EN_HIGH_OFS, 8'h00);
    wr(TMR_EXT_CTRL_OFS, 8'h50);
    check({30'h0, tmr1_run, tmr0_run}, 32'h3);
    rd_chk(TMR_EXT_CTRL_OFS, 8'h50);
    wr(TMR_EXT_CTRL_OFS, 8'h00);
    check({31'h0, hresp}, 32'h0);
    $display("test regs done");
  endtask

  // Timer 0 flag, enables and vectoring clear
  task automatic t_timer;
    pulse(0);
    pulse(0);
    check({20'h0, irq_pending}, 32'h0);
    rd_chk(TMR_EXT_CTRL_OFS, 8'h20);
    wr(IRQ_EN_LOW_OFS, 8'h02);
    repeat (3) @(posedge hclk);
    check({20'h0, irq_pending}, 32'h0);
    wr(IRQ_EN_LOW_OFS, 8'h82);
    repeat (5) @(posedge hclk);
    check({28'h0, last_src}, 32'h2);
    rd_chk(TMR_EXT_CTRL_OFS, 8'h00);
    wr(IRQ_EN_LOW_OFS, 8'h00);
    ret();
    $display("test timer done");
  endtask

  // Serial and timer 2 flags stay through vectoring, software clears them
  task automatic t_keep;
    pulse(2);
    pulse(4);
    wr(IRQ_EN_LOW_OFS, 8'hb0);
    repeat (5) @(posedge hclk);
    check({20'h0, irq_pending}, 32'h500);
    check({28'h0, last_src}, 32'h8);
    wr(IRQ_EN_LOW_OFS, 8'ha0);
    ret();
    check({28'h0, last_src}, 32'ha);
    wr(IRQ_EN_LOW_OFS, 8'h00);
    ret();
    rd_chk(SERIAL_FLAGS_OFS, 8'h01);
    rd_chk(IRQ_REQ_OFS, 8'h40);
    wr(SERIAL_FLAGS_OFS, 8'h00);
    wr(IRQ_REQ_OFS, 8'h00);
    rd_chk(SERIAL_FLAGS_OFS, 8'h00);
    pulse(5);
    rd_chk(IRQ_REQ_OFS, 8'h00);
    wr(IRQ_EN_HIGH_OFS, 8'h80);
    pulse(5);
    rd_chk(IRQ_REQ_OFS, 8'h80);
    wr(IRQ_REQ_OFS, 8'h00);
    wr(IRQ_EN_HIGH_OFS, 8'h00);
    $display("test keep done");
  endtask

  // Converter and external 2..6 each behind its own enable
  task automatic t_high;
    for (int i = 0; i < 6; i++) begin
      wr(IRQ_EN_HIGH_OFS, 8'h01 << i);
      wr(IRQ_EN_LOW_OFS, 8'h80);
      pulse(6 + i);
      check({28'h0, last_src}, 32'(2 * i + 1));
      wr(IRQ_EN_LOW_OFS, 8'h00);
      ret();
      rd_chk(IRQ_REQ_OFS, (i == 0) ? 8'h01 : 8'h00);
      wr(IRQ_REQ_OFS, 8'h00);
    end
    wr(IRQ_EN_HIGH_OFS, 8'h00);
    $display("test high done");
  endtask

  // External 0 in level mode and then in falling-edge mode
  task automatic t_ext0;
    wr(IRQ_EN_LOW_OFS, 8'h81);
    pin0 <= 1'b0;
    pin1 <= 1'b0;
    repeat (5) @(posedge hclk);
    check({28'h0, last_src}, 32'h0);
    rd_chk(TMR_EXT_CTRL_OFS, 8'h0a);
    pin0 <= 1'b1;
    pin1 <= 1'b1;
    repeat (3) @(posedge hclk);
    rd_chk(TMR_EXT_CTRL_OFS, 8'h00);
    wr(IRQ_EN_LOW_OFS, 8'h00);
    ret();
    wr(TMR_EXT_CTRL_OFS, 8'h01);
    pin0 <= 1'b0;
    repeat (3) @(posedge hclk);
    pin0 <= 1'b1;
    rd_chk(TMR_EXT_CTRL_OFS, 8'h03);
    cnt = ack_count;
    wr(IRQ_EN_LOW_OFS, 8'h81);
    repeat (5) @(posedge hclk);
    check({24'h0, ack_count}, {24'h0, cnt + 8'h01});
    rd_chk(TMR_EXT_CTRL_OFS, 8'h01);
    wr(IRQ_EN_LOW_OFS, 8'h00);
    wr(TMR_EXT_CTRL_OFS, 8'h00);
    ret();
    $display("test ext0 done");
  endtask

  // Pair levels and preemption by strictly higher levels only
  task automatic t_prio;
    wr(PRIO_LOW_OFS, 8'h0a);
    wr(PRIO_HIGH_OFS, 8'h08);
    wr(IRQ_EN_HIGH_OFS, 8'h02);
    wr(IRQ_EN_LOW_OFS, 8'h8a);
    cnt = ack_count;
    pulse(0);
    check({28'h0, last_src}, 32'h2);
    pulse(7);
    check({24'h0, ack_count}, {24'h0, cnt + 8'h01});
    pulse(1);
    check({28'h0, last_src}, 32'h6);
    bus(1'b0, IRQ_STATUS_OFS, 8'h00);
    check(rd, 32'h0000a008);
    check({25'h0, cpu_offer}, {25'h0, 1'b0, 4'h3, 2'h1});
    ret();
    check({24'h0, ack_count}, {24'h0, cnt + 8'h02});
    ret();
    check({28'h0, last_src}, 32'h3);
    wr(IRQ_EN_LOW_OFS, 8'h00);
    ret();
    $display("test prio done");
  endtask

  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, ret_req} = 4'h0;
    {pin0, pin1} = 2'b11;
    {haddr, hwdata, htrans, evt} = '0;
    err_count = 0;
    tests_run = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_timer();
    t_keep();
    t_high();
    t_ext0();
    t_prio();
    conclude();
  end

  // Hang limit
  initial begin
    #5000000;
    err_count++;
    conclude();
  end
endmodule
